/* pkg/conv_out_defs.vh */
// Constants for the converter output clocking and control-mode block
`ifndef CONV_OUT_DEFS_VH
`define CONV_OUT_DEFS_VH
`define FRAME_BITS      6'd32
`define FRAME_HEADER    12'h001
`define ADDR_CONFIG     4'h1
`define ADDR_OFFSET     4'h2
`define ADDR_RANGE      4'h3
`define ADDR_FINE       4'hd
`define ADDR_COARSE     4'he
`define ADDR_PATTERN    4'hf
`define CFG_RESET       16'h9eff
`define OFFSET_RESET    16'h0000
`define RANGE_RESET     16'h8000
`define FINE_RESET      16'h0000
`define COARSE_RESET    16'h0000
`define PATTERN_RESET   16'h0000
`define CFG_DRE_BIT     14
`define CFG_DCS_BIT     12
`define CFG_DCP_BIT     11
`define CFG_NDE_BIT     10
`define CFG_OE_BIT      8
`define PAT_TPO_BIT     11
`define FIELD_HI        15
`define FIELD_LO        7
`define FIELD_ZERO      9'h000
`define FIELD_MID       9'h100
`define TEST_WORD_A     8'h55
`define TEST_WORD_B     8'haa
`define PHASE_CNT_W     4
`define SETTLE_LAST     3'h7
`endif

/* hw/edge_sync.v */
// Three-stage synchroniser with agreement filter for one external input
`timescale 1ns/1ps
module edge_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change only when second and third stages agree
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end
  assign rise = (s2_reg == s3_reg) && s3_reg && !level;
  assign fall = (s2_reg == s3_reg) && !s3_reg && level;
endmodule // edge_sync

/* hw/word_fifo.v */
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  always @(posedge clk) begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // word_fifo

/* hw/conv_out_ctrl.v */
// Output clocking, control mode and serial register block of the converter
`timescale 1ns/1ps
`include "conv_out_defs.vh"
module conv_out_ctrl #(
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       read_clock,
  input  wire       power_down_input,
  input  wire       range_or_control_select,
  input  wire       output_edge_select,
  input  wire       output_edge_float,
  input  wire       cal_delay_select,
  input  wire       serial_clock,
  input  wire       serial_data,
  input  wire       serial_select_n,
  input  wire [7:0] sample_rise,
  input  wire [7:0] sample_fall,
  input  wire       sample_valid,
  output wire       sample_ready,
  input  wire       read_enable,
  output reg  [7:0] data_out,
  output reg        output_strobe,
  output reg        buffer_empty_flag,
  output reg        buffer_full_flag,
  output reg        extended_mode,
  output reg        double_rate,
  output reg        long_cal_delay,
  output reg  [8:0] range_code,
  output reg  [8:0] offset_code,
  output reg  [15:0] phase_fine,
  output reg  [15:0] phase_coarse,
  output reg        duty_correct_en,
  output reg        diff_clock_reset,
  output reg        core_enable,
  output reg  [`PHASE_CNT_W-1:0] edge_trim
);
  // Serial registers
  reg [15:0] configuration_reg;
  reg [15:0] offset_adjust_reg;
  reg [15:0] full_scale_voltage_reg;
  reg [15:0] clock_phase_fine_reg;
  reg [15:0] clock_phase_coarse_reg;
  reg [15:0] test_pattern_and_buffer_reg;
  reg [31:0] shift_reg;
  reg [5:0]  bit_cnt_reg;
  reg        mode_latched_reg;
  reg        pattern_sel_reg;
  reg        lane_reg;
  reg        phase_dir_reg;

  wire rclk_rise;
  wire rclk_fall;
  wire sclk_rise;
  wire sel_n_lvl;
  wire sdata_lvl;
  wire pd_lvl;
  wire mode_lvl;
  wire edge_lvl;
  wire float_lvl;
  wire cal_lvl;

  // Read clock is only sampled, never used as a clock
  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_rclk (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (read_clock),
    .level (),
    .rise  (rclk_rise),
    .fall  (rclk_fall)
  );

  // Serial clock idles low, so no false edge after reset
  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_sclk (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (serial_clock),
    .level (),
    .rise  (sclk_rise),
    .fall  ()
  );

  // Select resets deasserted so a frame cannot start in reset
  edge_sync #(
    .RESET_VAL(1'b1)
  ) u_scs (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (serial_select_n),
    .level (sel_n_lvl),
    .rise  (),
    .fall  ()
  );

  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_sdat (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (serial_data),
    .level (sdata_lvl),
    .rise  (),
    .fall  ()
  );

  // Power down assumed until the pin is seen low
  edge_sync #(
    .RESET_VAL(1'b1)
  ) u_pd (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (power_down_input),
    .level (pd_lvl),
    .rise  (),
    .fall  ()
  );

  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_mode (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (range_or_control_select),
    .level (mode_lvl),
    .rise  (),
    .fall  ()
  );

  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (output_edge_select),
    .level (edge_lvl),
    .rise  (),
    .fall  ()
  );

  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_float (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (output_edge_float),
    .level (float_lvl),
    .rise  (),
    .fall  ()
  );

  edge_sync #(
    .RESET_VAL(1'b0)
  ) u_cal (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cal_delay_select),
    .level (cal_lvl),
    .rise  (),
    .fall  ()
  );

  // Mode pin sampled once the synchroniser has settled, then frozen
  reg [2:0] settle_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      settle_reg       <= 3'h0;
      mode_latched_reg <= 1'b0;
      extended_mode    <= 1'b0;
    end else if (!mode_latched_reg) begin
      settle_reg <= settle_reg + 3'h1;
      if (settle_reg == `SETTLE_LAST) begin
        mode_latched_reg <= 1'b1;
        extended_mode    <= mode_lvl;
      end
    end
  end

  // Serial write frame: header, address, data, MSB first
  wire [31:0] frame_next = {shift_reg[30:0], sdata_lvl};
  always @(posedge clk) begin
    if (!rst_n) begin
      shift_reg                   <= 32'h0000_0000;
      bit_cnt_reg                 <= 6'h00;
      configuration_reg           <= `CFG_RESET;
      offset_adjust_reg           <= `OFFSET_RESET;
      full_scale_voltage_reg      <= `RANGE_RESET;
      clock_phase_fine_reg        <= `FINE_RESET;
      clock_phase_coarse_reg      <= `COARSE_RESET;
      test_pattern_and_buffer_reg <= `PATTERN_RESET;
    end else if (sel_n_lvl || !extended_mode) begin
      bit_cnt_reg <= 6'h00;
    end else if (sclk_rise) begin
      shift_reg <= frame_next;
      if (bit_cnt_reg == `FRAME_BITS - 6'h01) begin
        // Back-to-back frames allowed without releasing select
        bit_cnt_reg <= 6'h00;
        if (frame_next[31:20] == `FRAME_HEADER) begin
          if (frame_next[19:16] == `ADDR_CONFIG)
            configuration_reg <= frame_next[15:0];
          else if (frame_next[19:16] == `ADDR_OFFSET)
            offset_adjust_reg <= frame_next[15:0];
          else if (frame_next[19:16] == `ADDR_RANGE)
            full_scale_voltage_reg <= frame_next[15:0];
          else if (frame_next[19:16] == `ADDR_FINE)
            clock_phase_fine_reg <= frame_next[15:0];
          else if (frame_next[19:16] == `ADDR_COARSE)
            clock_phase_coarse_reg <= frame_next[15:0];
          else if (frame_next[19:16] == `ADDR_PATTERN)
            test_pattern_and_buffer_reg <= frame_next[15:0];
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  // Effective controls: registers only count in extended mode
  reg dcp_eff;
  reg rise_edge_eff;
  reg tpo_eff;
  always @(posedge clk) begin
    if (!rst_n) begin
      double_rate      <= 1'b0;
      dcp_eff          <= 1'b0;
      rise_edge_eff    <= 1'b0;
      tpo_eff          <= 1'b0;
      long_cal_delay   <= 1'b0;
      range_code       <= `FIELD_MID;
      offset_code      <= `FIELD_ZERO;
      phase_fine       <= `FINE_RESET;
      phase_coarse     <= `COARSE_RESET;
      duty_correct_en  <= 1'b1;
      diff_clock_reset <= 1'b0;
      core_enable      <= 1'b0;
    end else if (extended_mode) begin
      double_rate      <= !configuration_reg[`CFG_NDE_BIT];
      dcp_eff          <= configuration_reg[`CFG_DCP_BIT];
      rise_edge_eff    <= configuration_reg[`CFG_OE_BIT];
      tpo_eff          <= test_pattern_and_buffer_reg[`PAT_TPO_BIT];
      long_cal_delay   <= 1'b0;
      range_code       <= full_scale_voltage_reg[`FIELD_HI:`FIELD_LO];
      offset_code      <= offset_adjust_reg[`FIELD_HI:`FIELD_LO];
      phase_fine       <= clock_phase_fine_reg;
      phase_coarse     <= clock_phase_coarse_reg;
      duty_correct_en  <= configuration_reg[`CFG_DCS_BIT];
      diff_clock_reset <= configuration_reg[`CFG_DRE_BIT];
      core_enable      <= !pd_lvl;
    end else begin
      double_rate      <= float_lvl;
      dcp_eff          <= 1'b0;
      rise_edge_eff    <= edge_lvl;
      tpo_eff          <= 1'b0;
      long_cal_delay   <= cal_lvl;
      range_code       <= `FIELD_MID;
      offset_code      <= `FIELD_ZERO;
      phase_fine       <= `FINE_RESET;
      phase_coarse     <= `COARSE_RESET;
      duty_correct_en  <= 1'b1;
      diff_clock_reset <= 1'b0;
      core_enable      <= !pd_lvl;
    end
  end

  // Background trim toggles direction; stands in for the analog loop
  always @(posedge clk) begin
    if (!rst_n) begin
      edge_trim     <= {`PHASE_CNT_W{1'b0}};
      phase_dir_reg <= 1'b0;
    end else if (core_enable) begin
      phase_dir_reg <= !phase_dir_reg;
      edge_trim     <= phase_dir_reg ? edge_trim - 1'b1 : edge_trim + 1'b1;
    end
  end

  // Both sample halves enter the buffer in turn; writes stop in power down
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       fifo_pop;
  wire       fifo_push = sample_valid && core_enable;
  assign sample_ready = fifo_in_ready && core_enable && lane_reg;
  always @(posedge clk) begin
    if (!rst_n)
      lane_reg <= 1'b0;
    else if (fifo_push && fifo_in_ready)
      lane_reg <= !lane_reg;
  end

  word_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(lane_reg ? sample_fall : sample_rise),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Output side advances only on read clock edges; works in power down
  reg  strobe_phase_reg;
  wire sdr_step = rise_edge_eff ? rclk_rise : rclk_fall;
  wire ddr_step = rclk_rise;
  wire out_step = double_rate ? ddr_step : sdr_step;
  assign fifo_pop = out_step && read_enable && fifo_out_valid;
  always @(posedge clk) begin
    if (!rst_n) begin
      data_out          <= 8'h00;
      output_strobe     <= 1'b0;
      strobe_phase_reg  <= 1'b0;
      buffer_empty_flag <= 1'b1;
      buffer_full_flag  <= 1'b0;
      pattern_sel_reg   <= 1'b0;
    end else begin
      buffer_empty_flag <= !fifo_out_valid;
      buffer_full_flag  <= !fifo_in_ready;
      if (out_step && read_enable) begin
        pattern_sel_reg <= !pattern_sel_reg;
        if (tpo_eff)
          data_out <= pattern_sel_reg ? `TEST_WORD_B : `TEST_WORD_A;
        else if (fifo_out_valid)
          data_out <= fifo_out_data;
      end
      if (double_rate) begin
        // One strobe edge per word: strobe runs at half the data rate
        if (ddr_step) begin
          strobe_phase_reg <= !strobe_phase_reg;
          if (!dcp_eff)
            output_strobe <= !output_strobe;
        end else if (dcp_eff && rclk_fall) begin
          output_strobe <= strobe_phase_reg;
        end
      end else begin
        if (rclk_rise)
          output_strobe <= 1'b1;
        else if (rclk_fall)
          output_strobe <= 1'b0;
      end
    end
  end
endmodule // conv_out_ctrl

/* bench/conv_out_ctrl_sva.sv */
// Port-level checks for the output clocking and control block
`timescale 1ns/1ps
module conv_out_ctrl_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        power_down_input,
  input wire        serial_select_n,
  input wire        sample_ready,
  input wire        read_enable,
  input wire [7:0]  data_out,
  input wire        buffer_empty_flag,
  input wire        buffer_full_flag,
  input wire        extended_mode,
  input wire        long_cal_delay,
  input wire [8:0]  range_code,
  input wire [8:0]  offset_code,
  input wire [15:0] phase_fine,
  input wire        core_enable
);
  reg [3:0] since_rst;
  reg [4:0] sel_idle;
  // Idle count lets a frame finish landing before registers must hold
  always @(posedge clk) begin
    if (!rst_n) begin
      since_rst <= 4'h0;
      sel_idle  <= 5'h00;
    end else begin
      if (since_rst != 4'hf)
        since_rst <= since_rst + 4'h1;
      if (!serial_select_n)
        sel_idle <= 5'h00;
      else if (sel_idle != 5'h1f)
        sel_idle <= sel_idle + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pd_held;
    power_down_input [*8];
  endsequence
  pd_core_a: assert property (pd_held |-> !core_enable)
    else $error("core on in power down");
  pd_ready_a: assert property (!core_enable |-> !sample_ready)
    else $error("sample taken in power down");
  mode_hold_a: assert property (
    since_rst > 4'hc |-> $stable(extended_mode))
    else $error("control mode changed");
  normal_regs_a: assert property (
    !extended_mode |-> offset_code == 9'h000 && phase_fine == 16'h0000)
    else $error("register effect in normal mode");
  ext_cal_a: assert property (extended_mode [*3] |-> !long_cal_delay)
    else $error("long delay in extended mode");
  quiet_regs_a: assert property (
    sel_idle > 5'h14 |-> $stable(range_code) && $stable(offset_code))
    else $error("register changed without frame");
  flags_excl_a: assert property (buffer_full_flag |-> !buffer_empty_flag)
    else $error("full and empty together");
  data_cause_a: assert property ($changed(data_out) |-> $past(read_enable))
    else $error("data changed without read");
  // Two idle core cycles rule out a write already in flight
  sequence core_off_empty;
    (!core_enable) [*2] ##0 buffer_empty_flag;
  endsequence
  pd_no_write_a: assert property (core_off_empty |=> buffer_empty_flag)
    else $error("buffer written in power down");
endmodule // conv_out_ctrl_sva
bind conv_out_ctrl conv_out_ctrl_sva i_conv_out_ctrl_sva (.clk, .rst_n,
  .power_down_input, .serial_select_n, .sample_ready, .read_enable,
  .data_out, .buffer_empty_flag, .buffer_full_flag, .extended_mode,
  .long_cal_delay, .range_code, .offset_code, .phase_fine, .core_enable);

/* bench/host_model.sv */
// Host side: free-running read clock and serial register writer
`timescale 1ns/1ps
module host_model (
  input  wire clk,
  output reg  read_clock,
  output reg  serial_clock,
  output reg  serial_data,
  output reg  serial_select_n
);
  initial begin
    read_clock = 1'b0;
    serial_clock = 1'b0;
    serial_data = 1'b1;
    serial_select_n = 1'b1;
    #37;
    forever #100 read_clock = ~read_clock;
  end
  // Serial clock stands still between frames; halves of 8 cycles each
  task send_frame(input [11:0] hdr, input [3:0] addr, input [15:0] val);
    reg [31:0] frame;
    integer    k;
    begin
      frame = {hdr, addr, val};
      @(posedge clk);
      serial_select_n <= 1'b0;
      for (k = 31; k >= 0; k = k - 1) begin
        serial_data <= frame[k];
        repeat (8) @(posedge clk);
        serial_clock <= 1'b1;
        repeat (8) @(posedge clk);
        serial_clock <= 1'b0;
      end
      repeat (8) @(posedge clk);
      serial_select_n <= 1'b1;
      serial_data <= ~frame[0];
    end
  endtask
endmodule // host_model

/* bench/testbench.sv */
// Bench: mode selection, serial registers, capture and read-out
`timescale 1ns/1ps
`include "conv_out_defs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         power_down_input = 1'b0;
  reg         range_or_control_select = 1'b0;
  reg         output_edge_select = 1'b1;
  reg         output_edge_float = 1'b1;
  reg         cal_delay_select = 1'b1;
  reg         sample_valid = 1'b0;
  reg         read_enable = 1'b0;
  reg  [7:0]  sample_rise = 8'h00;
  reg  [7:0]  sample_fall = 8'h00;
  wire        read_clock, serial_clock, serial_data, serial_select_n;
  wire        sample_ready, output_strobe, buffer_empty_flag;
  wire        buffer_full_flag, extended_mode, double_rate;
  wire        long_cal_delay, duty_correct_en, diff_clock_reset;
  wire        core_enable;
  wire [7:0]  data_out;
  wire [8:0]  range_code, offset_code;
  wire [15:0] phase_fine, phase_coarse;
  wire [`PHASE_CNT_W-1:0] edge_trim;
  integer     fails = 0;
  integer     n_compared = 0;
  integer     i;
  reg         ok;
  reg  [7:0]  got, prev;
  reg  [39:0] seq = 40'h1122334444;
  always #12.5 clk = ~clk;
  host_model i_host_model (.clk, .read_clock, .serial_clock,
    .serial_data, .serial_select_n);
  conv_out_ctrl i_conv_out_ctrl (.clk, .rst_n, .read_clock,
    .power_down_input, .range_or_control_select, .output_edge_select,
    .output_edge_float, .cal_delay_select, .serial_clock, .serial_data,
    .serial_select_n, .sample_rise, .sample_fall, .sample_valid,
    .sample_ready, .read_enable, .data_out, .output_strobe,
    .buffer_empty_flag, .buffer_full_flag, .extended_mode, .double_rate,
    .long_cal_delay, .range_code, .offset_code, .phase_fine, .phase_coarse,
    .duty_correct_en, .diff_clock_reset, .core_enable, .edge_trim);
  task check_flag(input [8*9:1] what, input exp, input seen);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected %0s: expected %b, seen %b", what, exp, seen);
      end
    end
  endtask
  task check_word(input [8*9:1] what, input [15:0] exp, input [15:0] seen);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Outputs are looked at on the falling edge, clear of updates
  task idle(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task do_reset(input ext);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      range_or_control_select <= ext;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      idle(20);
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      i_host_model.send_frame(`FRAME_HEADER, a, v);
      idle(4);
    end
  endtask
  task push(input [7:0] r, input [7:0] f, output taken);
    integer k;
    begin
      taken = 1'b0;
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_rise <= r;
      sample_fall <= f;
      for (k = 0; k < 10 && !taken; k = k + 1) begin
        @(negedge clk);
        taken = (sample_ready === 1'b1);
      end
      @(posedge clk);
      sample_valid <= 1'b0;
    end
  endtask
  // One read step per read clock period; enable dropped before the next
  task rd(input sc, output [7:0] w);
    reg st;
    begin
      @(posedge read_clock);
      @(negedge clk);
      st = output_strobe;
      @(posedge clk);
      read_enable <= 1'b1;
      repeat (6) @(posedge clk);
      read_enable <= 1'b0;
      @(negedge clk);
      w = data_out;
      if (sc)
        check_flag("strobe", ~st, output_strobe);
    end
  endtask
  initial begin
    do_reset(1'b0);
    check_flag("ddr", 1'b1, double_rate);
    check_flag("long_cal", 1'b1, long_cal_delay);
    wr(`ADDR_OFFSET, 16'hffff);
    check_word("offset", 16'h0000, offset_code);
    @(posedge clk);
    output_edge_float <= 1'b0;
    range_or_control_select <= 1'b1;
    idle(12);
    check_flag("ddr", 1'b0, double_rate);
    check_flag("ext_mode", 1'b0, extended_mode);
    do_reset(1'b1);
    check_flag("ext_mode", 1'b1, extended_mode);
    check_flag("ddr", 1'b0, double_rate);
    check_flag("long_cal", 1'b0, long_cal_delay);
    check_flag("duty_corr", 1'b1, duty_correct_en);
    check_flag("diff_rst", 1'b0, diff_clock_reset);
    check_word("range", 16'h0100, range_code);
    check_word("coarse", 16'h0000, phase_coarse);
    prev = {4'h0, edge_trim};
    idle(0);
    check_flag("trim", 1'b1, {4'h0, edge_trim} !== prev);
    wr(`ADDR_OFFSET, 16'hff80);
    wr(`ADDR_RANGE, 16'h0080);
    wr(`ADDR_FINE, 16'h1234);
    wr(`ADDR_COARSE, 16'habcd);
    i_host_model.send_frame(12'h003, `ADDR_OFFSET, 16'h0000);
    wr(4'h4, 16'h0000);
    check_word("offset", 16'h01ff, offset_code);
    check_word("range", 16'h0001, range_code);
    check_word("fine", 16'h1234, phase_fine);
    check_word("coarse", 16'habcd, phase_coarse);
    wr(`ADDR_CONFIG, 16'hc2ff);
    check_flag("ddr", 1'b1, double_rate);
    check_flag("duty_corr", 1'b0, duty_correct_en);
    check_flag("diff_rst", 1'b1, diff_clock_reset);
    @(posedge clk);
    power_down_input <= 1'b1;
    idle(8);
    check_flag("core_en", 1'b0, core_enable);
    prev = {4'h0, edge_trim};
    idle(0);
    check_flag("trim", 1'b0, {4'h0, edge_trim} !== prev);
    push(8'h01, 8'h02, ok);
    check_flag("taken", 1'b0, ok);
    check_flag("empty", 1'b1, buffer_empty_flag);
    @(posedge clk);
    power_down_input <= 1'b0;
    idle(8);
    push(8'h11, 8'h22, ok);
    push(8'h33, 8'h44, ok);
    idle(2);
    check_flag("full", 1'b1, buffer_full_flag);
    @(posedge clk);
    power_down_input <= 1'b1;
    idle(8);
    for (i = 0; i < 5; i = i + 1) begin
      rd(i < 4, got);
      check_word("data", {8'h00, seq[39-8*i -: 8]}, {8'h00, got});
    end
    check_flag("empty", 1'b1, buffer_empty_flag);
    @(posedge clk);
    power_down_input <= 1'b0;
    wr(`ADDR_PATTERN, 16'h0800);
    rd(1'b1, prev);
    rd(1'b1, got);
    check_flag("pattern", 1'b1, prev === 8'h55 || prev === 8'haa);
    check_word("pattern", {8'h00, ~prev}, {8'h00, got});
    // Single rate, data on rising strobe edge, strobe follows read clock
    wr(`ADDR_CONFIG, 16'h9fff);
    check_flag("ddr", 1'b0, double_rate);
    @(posedge read_clock);
    idle(5);
    check_flag("strobe", 1'b1, output_strobe);
    @(negedge read_clock);
    idle(5);
    check_flag("strobe", 1'b0, output_strobe);
    rd(1'b0, got);
    check_word("pattern", {8'h00, prev}, {8'h00, got});
    complete_run;
  end
  initial begin
    #1000000;
    fails = fails + 1;
    complete_run;
  end
endmodule // testbench
